/* File: inc/pfo_pkg.sv */
// How it works
// - Shortest pulse-width period is one 1 us step, so the highest rate is 1 MHz.
// - Each pulse-width output has its own duty, from zero steps up to the full period.
// - Period and duty count in 1 us steps, so resolution equals period over 1 us.
// - Each of sixteen pins selects plain level, pulse-width or fixed-rate drive.
// - Hardware counters make the waveforms; software only writes settings.
// - Fixed-rate pins share one phase accumulator; each pin keeps its own duty.
// - Fixed-rate increment is clamped to 4 MHz, zero stops it; duty resets to half.
package pfo_pkg;
	localparam int NPIN    = 16;
	localparam int ADDR_W  = 8;
	localparam int PWM_W   = 16;
	localparam int FIXD_W  = 9;
	localparam int PHASE_W = 32;

	localparam int CLK_PERIOD_NS = 20;
	localparam int PWM_STEP_NS   = 1000;
	localparam int STEP_CYCLES   = (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_CNT_W    = $clog2(STEP_CYCLES);

	localparam longint CLK_HZ      = 64'd50_000_000;
	localparam longint FIX_MAX_HZ  = 64'd4_000_000;
	localparam logic [31:0] FIX_INC_MAX = 32'((FIX_MAX_HZ * 64'h1_0000_0000) / CLK_HZ);

	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_PERIOD  = 8'h04;
	localparam logic [7:0] OFS_FIXINC  = 8'h08;
	localparam logic [7:0] OFS_FUNC    = 8'h0C;
	localparam logic [7:0] OFS_GPIO    = 8'h10;
	localparam logic [7:0] OFS_STATUS  = 8'h14;
	localparam logic [7:0] OFS_PWMDUTY = 8'h40;
	localparam logic [7:0] OFS_FIXDUTY = 8'h80;

	localparam int CTRL_PWM_EN = 0;
	localparam int CTRL_FIX_EN = 1;
	localparam int GPIO_DIR_LSB = 16;

	localparam logic [1:0]  RST_CTRL    = 2'h0;
	localparam logic [15:0] RST_PERIOD  = 16'h0000;
	localparam logic [31:0] RST_FIXINC  = 32'h0000_0000;
	localparam logic [31:0] RST_FUNC    = 32'h0000_0000;
	localparam logic [31:0] RST_GPIO    = 32'h0000_0000;
	localparam logic [15:0] RST_PWMDUTY = 16'h0000;
	localparam logic [8:0]  RST_FIXDUTY = 9'h080;

	typedef enum logic [1:0] {
		PFO_FN_GPIO = 2'b00,
		PFO_FN_PWM  = 2'b01,
		PFO_FN_FIX  = 2'b10,
		PFO_FN_OFF  = 2'b11
	} pfo_func_t;

	function automatic logic pfo_window(input logic [7:0] addr, input logic [7:0] base);
		return addr[7:6] == base[7:6];
	endfunction : pfo_window

	function automatic logic pfo_below(input logic [15:0] cnt, input logic [15:0] lim);
		return cnt < lim;
	endfunction : pfo_below
endpackage : pfo_pkg

/* File: inc/pfo_tick_if.sv */
`timescale 1ns/1ps
interface pfo_tick_if;
	logic        pwmLoad;
	logic        pwmOff;
	logic [15:0] pwmCount;
	logic        fixLoad;
	logic        fixOff;
	logic [7:0]  fixPhase;

	modport src (output pwmLoad, output pwmOff, output pwmCount,
	             output fixLoad, output fixOff, output fixPhase);
	modport snk (input pwmLoad, input pwmOff, input pwmCount,
	             input fixLoad, input fixOff, input fixPhase);
endinterface : pfo_tick_if

/* File: src/pfo_pin_gen.sv */
`timescale 1ns/1ps
module pfo_pin_gen
	import pfo_pkg::*;
(
	input  wire logic              clk,       // System clock.
	input  wire logic              rstn,      // Synchronous reset, active low.
	input  wire logic              ce,        // Clock enable.
	input  wire logic [1:0]        func,      // Pin function select.
	input  wire logic              gpioLevel, // Plain output level.
	input  wire logic [PWM_W-1:0]  pwmDuty,   // Pulse-width duty in steps.
	input  wire logic [FIXD_W-1:0] fixDuty,   // Fixed-rate duty in 1/256.
	pfo_tick_if.snk                tick,      // Shared counters.
	output logic                   pinLevel   // Registered pin level.
);
	logic [PWM_W-1:0]  pwmShadow;
	logic [FIXD_W-1:0] fixShadow;

	// Duties take effect only at a period boundary or while the timebase is idle, so no runt pulse appears.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwmShadow <= RST_PWMDUTY;
			fixShadow <= RST_FIXDUTY;
		end else if (ce) begin
			if (tick.pwmLoad)
				pwmShadow <= pwmDuty;
			if (tick.fixLoad)
				fixShadow <= fixDuty;
		end
	end

	wire logic pwmWave = !tick.pwmOff && pfo_below(tick.pwmCount, pwmShadow);
	wire logic fixWave = !tick.fixOff &&
		pfo_below({8'h00, tick.fixPhase}, {7'h00, fixShadow});
	wire logic next_pinLevel = (func == PFO_FN_PWM)  ? pwmWave :
	                           (func == PFO_FN_FIX)  ? fixWave :
	                           (func == PFO_FN_GPIO) ? gpioLevel : 1'b0;

	always_ff @(posedge clk) begin
		if (!rstn)
			pinLevel <= 1'b0;
		else if (ce)
			pinLevel <= next_pinLevel;
	end
endmodule : pfo_pin_gen

/* File: src/pfo_top.sv */
`timescale 1ns/1ps
module pfo_top
	import pfo_pkg::*;
(
	input  wire logic              clk,     // 50 MHz system clock.
	input  wire logic              rstn,    // Synchronous reset, active low.
	input  wire logic              ce,      // Clock enable, freezes all state when low.
	input  wire logic [ADDR_W-1:0] addr,    // Register byte address.
	input  wire logic [31:0]       wdata,   // Write data.
	input  wire logic              we,      // Write strobe.
	input  wire logic              re,      // Read strobe.
	output logic [31:0]            rdata,   // Read data, valid the cycle after re.
	output logic [NPIN-1:0]        pinOut,  // Pin output levels.
	output logic [NPIN-1:0]        pinOe    // Pin output enables, high while driven.
);
	logic [1:0]        ctrl;
	logic [15:0]       period;
	logic [31:0]       fixInc;
	logic [31:0]       funcSel;
	logic [31:0]       gpio;
	logic [PWM_W-1:0]  pwmDuty [NPIN];
	logic [FIXD_W-1:0] fixDuty [NPIN];

	logic [STEP_CNT_W-1:0] stepCnt;
	logic [15:0]           periodShadow;
	logic [15:0]           pwmCount;
	logic [PHASE_W-1:0]    phase;
	logic [NPIN-1:0]       pinLevel;

	pfo_tick_if tick ();

	// Register decode.
	wire logic [3:0] idx       = addr[5:2];
	wire logic       wrCtrl    = we && addr == OFS_CTRL;
	wire logic       wrPeriod  = we && addr == OFS_PERIOD;
	wire logic       wrFixInc  = we && addr == OFS_FIXINC;
	wire logic       wrFunc    = we && addr == OFS_FUNC;
	wire logic       wrGpio    = we && addr == OFS_GPIO;
	wire logic       inPwmDuty = pfo_window(addr, OFS_PWMDUTY) && addr[1:0] == 2'b00;
	wire logic       inFixDuty = pfo_window(addr, OFS_FIXDUTY) && addr[1:0] == 2'b00;
	wire logic       wrPwmDuty = we && inPwmDuty;
	wire logic       wrFixDuty = we && inFixDuty;

	wire logic [31:0] rdSel =
		(addr == OFS_CTRL)   ? {30'h0, ctrl} :
		(addr == OFS_PERIOD) ? {16'h0, period} :
		(addr == OFS_FIXINC) ? fixInc :
		(addr == OFS_FUNC)   ? funcSel :
		(addr == OFS_GPIO)   ? gpio :
		(addr == OFS_STATUS) ? {16'h0, pinLevel} :
		inPwmDuty            ? {16'h0, pwmDuty[idx]} :
		inFixDuty            ? {23'h0, fixDuty[idx]} : 32'h0000_0000;
	wire logic [31:0] next_rdata = re ? rdSel : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl    <= RST_CTRL;
			period  <= RST_PERIOD;
			fixInc  <= RST_FIXINC;
			funcSel <= RST_FUNC;
			gpio    <= RST_GPIO;
			rdata   <= 32'h0000_0000;
		end else if (ce) begin
			if (wrCtrl)
				ctrl <= wdata[1:0];
			if (wrPeriod)
				period <= wdata[15:0];
			if (wrFixInc)
				fixInc <= wdata;
			if (wrFunc)
				funcSel <= wdata;
			if (wrGpio)
				gpio <= wdata;
			rdata <= next_rdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < NPIN; i++) begin
				pwmDuty[i] <= RST_PWMDUTY;
				fixDuty[i] <= RST_FIXDUTY;
			end
		end else if (ce) begin
			if (wrPwmDuty)
				pwmDuty[idx] <= wdata[PWM_W-1:0];
			if (wrFixDuty)
				fixDuty[idx] <= wdata[FIXD_W-1:0];
		end
	end

	// Pulse-width timebase: a 1 us step strobe drives the period counter.
	wire logic stepTick = stepCnt == STEP_CNT_W'(STEP_CYCLES - 1);
	wire logic pwmIdle  = !ctrl[CTRL_PWM_EN] || periodShadow == 16'h0000;
	wire logic pwmWrap  = stepTick && pwmCount == periodShadow - 16'h0001;
	// While idle the shadows keep loading, so a restart begins on fresh settings.
	wire logic pwmLoad  = pwmIdle || pwmWrap;
	wire logic [STEP_CNT_W-1:0] next_stepCnt =
		(pwmIdle || stepTick) ? '0 : stepCnt + STEP_CNT_W'(1);
	wire logic [15:0] next_pwmCount =
		pwmLoad ? 16'h0000 : stepTick ? pwmCount + 16'h0001 : pwmCount;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			stepCnt      <= '0;
			pwmCount     <= 16'h0000;
			periodShadow <= RST_PERIOD;
		end else if (ce) begin
			stepCnt  <= next_stepCnt;
			pwmCount <= next_pwmCount;
			if (pwmLoad)
				periodShadow <= period;
		end
	end

	// Fixed-rate timebase: a phase accumulator, so any rate needs no divider ratio.
	// Rates above the ceiling are clamped rather than aliased.
	wire logic [31:0] incEff = (fixInc > FIX_INC_MAX) ? FIX_INC_MAX : fixInc;
	wire logic        fixIdle = !ctrl[CTRL_FIX_EN] || incEff == 32'h0000_0000;
	wire logic [32:0] phaseSum = {1'b0, phase} + {1'b0, incEff};
	wire logic        fixCarry = phaseSum[32];
	wire logic [31:0] next_phase = fixIdle ? 32'h0000_0000 : phaseSum[31:0];

	always_ff @(posedge clk) begin
		if (!rstn)
			phase <= 32'h0000_0000;
		else if (ce)
			phase <= next_phase;
	end

	assign tick.pwmLoad  = pwmLoad;
	assign tick.pwmOff   = pwmIdle;
	assign tick.pwmCount = pwmCount;
	assign tick.fixLoad  = fixIdle || fixCarry;
	assign tick.fixOff   = fixIdle;
	assign tick.fixPhase = phase[31:24];

	for (genvar p = 0; p < NPIN; p++) begin : g_pin
		pfo_pin_gen u_pin (
			.clk       (clk),
			.rstn      (rstn),
			.ce        (ce),
			.func      (funcSel[2*p +: 2]),
			.gpioLevel (gpio[p]),
			.pwmDuty   (pwmDuty[p]),
			.fixDuty   (fixDuty[p]),
			.tick      (tick),
			.pinLevel  (pinLevel[p])
		);
	end

	// A pin is driven when pulse-width or fixed-rate drive is chosen, or plain level with its direction bit set.
	logic [NPIN-1:0] next_pinOe;
	always_comb begin
		next_pinOe = '0;
		for (int i = 0; i < NPIN; i++)
			next_pinOe[i] = (funcSel[2*i +: 2] == PFO_FN_PWM) ||
			                (funcSel[2*i +: 2] == PFO_FN_FIX) ||
			                ((funcSel[2*i +: 2] == PFO_FN_GPIO) && gpio[GPIO_DIR_LSB + i]);
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			pinOe <= '0;
		else if (ce)
			pinOe <= next_pinOe;
	end

	assign pinOut = pinLevel;
endmodule : pfo_top

/* File: sim/pfo_load.sv */
`timescale 1ns/1ps
module pfo_load
	import pfo_pkg::*;
(
	input  wire logic [NPIN-1:0] pinOut,  // Block pin levels.
	input  wire logic [NPIN-1:0] pinOe,   // Block drive enables.
	input  wire logic            clk,     // System clock.
	output logic      [NPIN-1:0] line,    // Level on each wire.
	output logic      [15:0]     highCnt  // Clocks with wire 0 high.
);
	// Each wire has a pull-down, so a released pin reads low and never its last value.
	logic [15:0] count = 16'h0000;
	assign line = pinOut & pinOe;
	assign highCnt = count;
	always @(posedge clk)
		count <= count + 16'(line[0]);
endmodule : pfo_load

/* File: sim/pfo_top_properties.sv */
`timescale 1ns/1ps
module pfo_top_properties
	import pfo_pkg::*;
(
	input wire logic              clk,    // Clock.
	input wire logic              rstn,   // Reset.
	input wire logic              ce,     // Enable.
	input wire logic [ADDR_W-1:0] addr,   // Address.
	input wire logic [31:0]       wdata,  // Write data.
	input wire logic              we,     // Write strobe.
	input wire logic              re,     // Read strobe.
	input wire logic [31:0]       rdata,  // Read data.
	input wire logic [NPIN-1:0]   pinOut, // Pins.
	input wire logic [NPIN-1:0]   pinOe   // Enables.
);
	logic [31:0] funcReg;
	// Shadow of the pin function select, so pin checks know which drive is chosen.
	always_ff @(posedge clk) begin
		if (!rstn)
			funcReg <= 32'h0;
		else if (ce && we && addr == OFS_FUNC)
			funcReg <= wdata;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	rst_clear_a: assert property ($rose(rstn) |-> rdata == '0 && pinOut == '0 && pinOe == '0)
		else $error("outputs not clear after reset");
	rdata_idle_a: assert property (ce && !re |=> rdata == 32'h0)
		else $error("read data without a read");
	unmapped_zero_a: assert property (ce && re && addr == 8'h20 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	status_pins_a: assert property (ce && re && addr == OFS_STATUS |=> rdata[15:0] == $past(pinOut))
		else $error("status differs from pins");
	gpio_drive_a: assert property (ce && we && addr == OFS_GPIO && wdata[31:16] == 16'hFFFF &&
		funcReg == 32'h0 ##1 ce |=> pinOut == $past(wdata[15:0], 2) && pinOe == 16'hFFFF)
		else $error("plain level late or wrong");
	off_undriven_a: assert property ($past(ce) && $past(funcReg) == '1 |-> pinOe == '0 && pinOut == '0)
		else $error("off pin still driven");
	pwm_min_high_a: assert property ($past(funcReg[1:0]) == 2'h1 && $rose(pinOut[0]) |-> pinOut[0] [*8])
		else $error("pulse shorter than a step");
	fix_rate_cap_a: assert property ($past(funcReg[1:0]) == 2'h2 && $rose(pinOut[0]) |=> (!$rose(pinOut[0])) [*8])
		else $error("fixed rate above limit");
	cover property (re && addr == OFS_STATUS);
	cover property (funcReg[1:0] == 2'h1 && $rose(pinOut[0]));
	cover property (funcReg[1:0] == 2'h2 && $rose(pinOut[0]));
endmodule : pfo_top_properties
bind pfo_top pfo_top_properties chk (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
	.we(we), .re(re), .rdata(rdata), .pinOut(pinOut), .pinOe(pinOe));

/* File: sim/test_pwm_and_fixed_rate_outputs.sv */
`timescale 1ns/1ps
module test_pwm_and_fixed_rate_outputs
	import pfo_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, we = 1'b0, re = 1'b0, pend = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, r, exq[$];
	logic [15:0] pinOut, pinOe, line, highCnt, c0;
	int miscompares = 0, comparisons = 0, seed = 43163;
	logic [7:0] ra[10] = '{OFS_CTRL, OFS_PERIOD, OFS_FIXINC, OFS_FUNC, OFS_GPIO, OFS_STATUS,
		OFS_PWMDUTY, 8'h7C, OFS_FIXDUTY, 8'h20};
	int pp[6] = '{2, 2, 2, 10, 10, 10}, pd[6] = '{0, 1, 2, 3, 10, 12};
	int fd[5] = '{128, 64, 0, 256, 128}, fe[5] = '{320, 160, 0, 640, 0};
	always #10 clk = ~clk;
	pfo_top dut (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .we(we), .re(re),
		.rdata(rdata), .pinOut(pinOut), .pinOe(pinOe));
	pfo_load load (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .line(line), .highCnt(highCnt));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("%0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exq.push_back(e);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		@(posedge clk);
	endtask : rd
	task automatic hi(input int n, input int e);
		c0 = highCnt;
		repeat (n) @(posedge clk);
		chk("high clocks", 32'(e), 32'(highCnt - c0));
	endtask : hi
	task automatic rst();
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
	endtask : rst
	always @(posedge clk) begin
		if (pend)
			chk("rdata", exq.pop_front(), rdata);
		pend <= re;
	end
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		rst();
		foreach (ra[i])
			rd(ra[i], ra[i] == OFS_FIXDUTY ? 32'(RST_FIXDUTY) : 32'h0);
		$display("reset test done");
		repeat (4) begin
			r = $random(seed);
			wr(OFS_GPIO, {16'hFFFF, r[15:0]});
			repeat (2) @(posedge clk);
			rd(OFS_STATUS, {16'h0, r[15:0]});
			chk("pin enables", 32'h0000_FFFF, 32'(pinOe));
		end
		// A write while the clock enable is low must leave every pin as it was.
		ce <= 1'b0;
		wr(OFS_GPIO, {16'hFFFF, ~r[15:0]});
		ce <= 1'b1;
		rd(OFS_STATUS, {16'h0, r[15:0]});
		wr(OFS_FUNC, 32'hFFFF_FFFF);
		repeat (2) @(posedge clk);
		rd(OFS_STATUS, 32'h0);
		chk("pin enables", 32'h0000_0000, 32'(pinOe));
		$display("pin test done");
		rst();
		wr(OFS_FUNC, 32'h4000_0001);
		wr(OFS_CTRL, 32'h1);
		foreach (pp[i]) begin
			wr(OFS_PERIOD, 32'(pp[i]));
			wr(OFS_PWMDUTY, 32'(pd[i]));
			repeat (100 * pp[i]) @(posedge clk);
			hi(100 * pp[i], 100 * (pd[i] < pp[i] ? pd[i] : pp[i]));
		end
		rd(OFS_STATUS, 32'h0001);
		wr(OFS_CTRL, 32'h0);
		repeat (600) @(posedge clk);
		hi(600, 0);
		$display("pulse test done");
		rst();
		wr(OFS_FUNC, 32'h2);
		wr(OFS_CTRL, 32'h2);
		foreach (fd[i]) begin
			wr(OFS_FIXINC, i == 4 ? 32'h0 : 32'h0400_0000);
			wr(OFS_FIXDUTY, 32'(fd[i]));
			repeat (128) @(posedge clk);
			hi(640, fe[i]);
		end
		// At the clamped rate every 25 clocks hold two periods with 12 high clocks.
		wr(OFS_FIXINC, 32'hFFFF_FFFF);
		repeat (128) @(posedge clk);
		hi(500, 240);
		$display("fixed rate test done");
		tally_and_finish();
	end
endmodule : test_pwm_and_fixed_rate_outputs
